/* count_step_if.sv */
// carrier between the timer core and its count stepper
`timescale 1ns/1ps
`default_nettype none
interface count_step_if;
  logic [31:0] cur;
  logic        up;
  logic        hms;
  logic [7:0]  hour_max;
  logic [31:0] nxt;
  logic        wrap;

  modport stepper (input cur, input up, input hms, input hour_max, output nxt, output wrap);
  modport owner   (output cur, output up, output hms, output hour_max, input nxt, input wrap);
endinterface : count_step_if
`default_nettype wire

/* count_stepper.sv */
// next count value in binary or hours:minutes:seconds:hundredths form
`timescale 1ns/1ps
`default_nettype none
`include "gp_timer_map.svh"
module count_stepper (
  count_step_if.stepper st
);

  logic [4:0]  carry;
  logic [31:0] hms_nxt;

  assign carry[0] = 1'b1;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_digit
      logic [7:0] d;
      logic [7:0] lim;
      logic       edge_hit;
      assign d        = st.cur[8*i +: 8];
      assign lim      = (i == 3) ? st.hour_max : ((i == 0) ? `HUND_MAX : `SEXA_MAX);
      assign edge_hit = st.up ? (d >= lim) : (d == 8'h00);
      assign carry[i+1] = carry[i] & edge_hit;
      always_comb begin
        if (!carry[i]) begin
          hms_nxt[8*i +: 8] = d;
        end else if (edge_hit) begin
          hms_nxt[8*i +: 8] = st.up ? 8'h00 : lim;
        end else begin
          hms_nxt[8*i +: 8] = st.up ? 8'(d + 8'h01) : 8'(d - 8'h01);
        end
      end
    end
  endgenerate

  always_comb begin
    if (st.hms) begin
      st.nxt  = hms_nxt;
      st.wrap = carry[4];
    end else begin
      st.nxt  = st.up ? 32'(st.cur + 32'h00000001) : 32'(st.cur - 32'h00000001);
      st.wrap = st.up ? (&st.cur) : ~(|st.cur);
    end
  end

endmodule : count_stepper
`default_nettype wire

/* gp_timer.sv */
// general purpose 32-bit up/down timer with apb registers
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gp_timer_map.svh"
module gp_timer #(
  parameter int NUM_EVENTS = `EVENT_COUNT,
  parameter int PRESC_W    = `PRESC_WIDTH
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  osc_32k,
  input  wire logic                  secondary_clock,
  input  wire logic                  external_count_pin,
  input  wire logic                  low_power_mode,
  input  wire logic [NUM_EVENTS-1:0] irq_sources,
  output logic                       timer_irq
);

  gp_timer_pkg::ctrl_t ctrl_ff;
  gp_timer_pkg::ctrl_t nxt_ctrl;

  logic [31:0]           reload_ff;
  logic [31:0]           nxt_reload;
  logic [31:0]           count_ff;
  logic [31:0]           nxt_count;
  logic [31:0]           capture_ff;
  logic [31:0]           nxt_capture;
  logic [7:0]            post_cnt_ff;
  logic [7:0]            nxt_post_cnt;
  logic                  irq_ff;
  logic                  nxt_irq;
  logic                  src_prev_ff;
  logic                  nxt_src_prev;
  logic [PRESC_W-1:0]    presc_cnt_ff;
  logic [PRESC_W-1:0]    nxt_presc_cnt;
  logic [NUM_EVENTS-1:0] evt_prev_ff;
  logic [NUM_EVENTS-1:0] nxt_evt_prev;
  logic [31:0]           prdata_ff;
  logic [31:0]           nxt_prdata;
  logic                  pready_ff;
  logic                  nxt_pready;
  logic                  pslverr_ff;
  logic                  nxt_pslverr;

  logic                  addr_hit;
  logic                  bus_done;
  logic                  wr_reload;
  logic                  wr_ctrl;
  logic                  wr_clear;
  logic                  src_level;
  logic                  src_core;
  logic                  src_edge;
  logic                  src_live;
  logic [PRESC_W-1:0]    presc_mask;
  logic                  tick;
  logic                  step;
  logic                  wrapped;
  logic                  post_hit;
  logic                  evt_valid;
  logic                  evt_rise;
  logic [31:0]           evt_pad;

  count_step_if stp ();

  count_stepper u_stepper (
    .st (stp.stepper)
  );

  // bus decode
  always_comb begin
    addr_hit = (paddr == `ADDR_RELOAD) || (paddr == `ADDR_COUNT) ||
               (paddr == `ADDR_CONTROL) || (paddr == `ADDR_CLEAR) ||
               (paddr == `ADDR_CAPTURE);
    bus_done  = psel & penable & pready_ff;
    wr_reload = bus_done & pwrite & (paddr == `ADDR_RELOAD);
    wr_ctrl   = bus_done & pwrite & (paddr == `ADDR_CONTROL);
    wr_clear  = bus_done & pwrite & (paddr == `ADDR_CLEAR);
  end

  // one wait state: answer registered in the first access cycle
  always_comb begin
    nxt_pready  = 1'b0;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = 1'b0;
    if (psel && penable && !pready_ff) begin
      nxt_pready  = 1'b1;
      nxt_pslverr = ~addr_hit;
      case (paddr)
        `ADDR_RELOAD:  nxt_prdata = reload_ff;
        `ADDR_COUNT:   nxt_prdata = count_ff;
        `ADDR_CONTROL: nxt_prdata = ctrl_ff;
        `ADDR_CLEAR:   nxt_prdata = `RST_WORD;
        `ADDR_CAPTURE: nxt_prdata = capture_ff;
        default:       nxt_prdata = `RST_WORD;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= `RST_WORD;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // control and reload registers
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_reload = reload_ff;
    if (wr_reload) begin
      nxt_reload = pwdata;
    end
    if (wr_ctrl) begin
      nxt_ctrl         = gp_timer_pkg::ctrl_t'(pwdata);
      // write enable and reserved bits always read back as zero
      nxt_ctrl.post_we = 1'b0;
      nxt_ctrl.rsv     = 3'h0;
      nxt_ctrl.cmp_flag = ctrl_ff.cmp_flag;
      if (!pwdata[`POST_WE_BIT]) begin
        nxt_ctrl.post = ctrl_ff.post;
      end
    end
    // compare flag: set wins over the clear write
    if (wr_clear) begin
      nxt_ctrl.cmp_flag = 1'b0;
    end
    if (post_hit) begin
      nxt_ctrl.cmp_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff   <= gp_timer_pkg::ctrl_t'(`RST_WORD);
      reload_ff <= `RST_WORD;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      reload_ff <= nxt_reload;
    end
  end

  // source select and prescaler; slow sources are sampled levels
  always_comb begin
    src_core = 1'b0;
    src_live = 1'b0;
    case (ctrl_ff.clk_sel)
      `CLK_SEL_OSC: begin
        src_level = osc_32k;
        src_live  = 1'b1;
      end
      `CLK_SEL_CORE: begin
        src_level = 1'b0;
        src_core  = 1'b1;
        src_live  = ~low_power_mode;
      end
      `CLK_SEL_SEC: begin
        src_level = secondary_clock;
        src_live  = ~low_power_mode;
      end
      `CLK_SEL_PIN: begin
        src_level = external_count_pin;
        src_live  = 1'b1;
      end
      default: begin
        src_level = 1'b0;
      end
    endcase
    // a freshly chosen source must not look like a rising edge
    if (wr_ctrl) begin
      nxt_src_prev = 1'b1;
    end else begin
      nxt_src_prev = src_level;
    end
    src_edge     = src_live & (src_core | (src_level & ~src_prev_ff));
    // sampled sources must stay below half the bus clock
    presc_mask   = PRESC_W'((32'h00000001 << ctrl_ff.presc) - 32'h00000001);
    tick         = src_edge & ((presc_cnt_ff & presc_mask) == presc_mask);
    // restart the divider on a control write so a new ratio starts clean
    if (wr_ctrl) begin
      nxt_presc_cnt = `RST_PRESC;
    end else if (src_edge) begin
      nxt_presc_cnt = PRESC_W'(presc_cnt_ff + 1'b1);
    end else begin
      nxt_presc_cnt = presc_cnt_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_ff  <= 1'b0;
      presc_cnt_ff <= `RST_PRESC;
    end else begin
      src_prev_ff  <= nxt_src_prev;
      presc_cnt_ff <= nxt_presc_cnt;
    end
  end

  // counter, postscaler and interrupt
  always_comb begin
    stp.cur      = count_ff;
    stp.up       = ctrl_ff.up;
    stp.hms      = (ctrl_ff.fmt == `FMT_HMS_23) || (ctrl_ff.fmt == `FMT_HMS_255);
    stp.hour_max = (ctrl_ff.fmt == `FMT_HMS_23) ? `HOUR_MAX_23 : `HOUR_MAX_255;
    step         = tick & ctrl_ff.en;
    wrapped      = step & stp.wrap;
    // a postscaler value of n fires on wrap n+1
    post_hit     = wrapped & (post_cnt_ff == ctrl_ff.post);
    nxt_count    = count_ff;
    if (wr_clear) begin
      nxt_count = reload_ff;
    end else if (step) begin
      if (stp.wrap && ctrl_ff.periodic) begin
        nxt_count = reload_ff;
      end else begin
        nxt_count = stp.nxt;
      end
    end
    if (wr_clear || post_hit) begin
      nxt_post_cnt = `RST_BYTE;
    end else if (wrapped) begin
      nxt_post_cnt = 8'(post_cnt_ff + 8'h01);
    end else begin
      nxt_post_cnt = post_cnt_ff;
    end
    // a wrap (with bit 18 set, a postscaler match) in the clear cycle keeps the interrupt pending
    nxt_irq = irq_ff & ~wr_clear;
    // bit 18 picks every wrap or only the postscaler match
    if (ctrl_ff.int_sel ? post_hit : wrapped) begin
      nxt_irq = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff    <= `RST_WORD;
      post_cnt_ff <= `RST_BYTE;
      irq_ff      <= 1'b0;
    end else begin
      count_ff    <= nxt_count;
      post_cnt_ff <= nxt_post_cnt;
      irq_ff      <= nxt_irq;
    end
  end

  // event capture on each rise of the chosen source
  always_comb begin
    evt_valid    = 32'(ctrl_ff.evt_sel) < NUM_EVENTS;
    // padded so a select past the sources reads zero, never off the vector
    evt_pad      = 32'(irq_sources & ~evt_prev_ff);
    evt_rise     = evt_valid && evt_pad[ctrl_ff.evt_sel];
    nxt_evt_prev = irq_sources;
    nxt_capture  = capture_ff;
    if (ctrl_ff.cap_en && evt_rise) begin
      nxt_capture = count_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_prev_ff <= '0;
      capture_ff  <= `RST_WORD;
    end else begin
      evt_prev_ff <= nxt_evt_prev;
      capture_ff  <= nxt_capture;
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign timer_irq = irq_ff;

endmodule : gp_timer
`default_nettype wire

/* gp_timer_checker.sv */
// port assertions of the general purpose timer
`timescale 1ns/1ps
`default_nettype none
`include "gp_timer_map.svh"
module gp_timer_checker #(
  parameter int NUM_EVENTS = `EVENT_COUNT
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  osc_32k,
  input wire logic                  secondary_clock,
  input wire logic                  external_count_pin,
  input wire logic                  low_power_mode,
  input wire logic [NUM_EVENTS-1:0] irq_sources,
  input wire logic                  timer_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic done, clr_wr, rd_ctl, mapped;
  assign done = psel && penable && pready;
  assign clr_wr = done && pwrite && paddr == `ADDR_CLEAR;
  assign rd_ctl = pready && !pwrite && paddr == `ADDR_CONTROL;
  assign mapped = paddr inside {`ADDR_RELOAD, `ADDR_COUNT, `ADDR_CONTROL, `ADDR_CLEAR, `ADDR_CAPTURE};
  chk_wait_state: assert property (psel && penable && !pready |=> pready) else $error("no ready");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  chk_ready_req: assert property (pready |-> psel && penable) else $error("stray ready");
  chk_err_map: assert property (pready |-> pslverr == !mapped) else $error("bad error flag");
  chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("err data");
  chk_clear_wo: assert property (pready && !pwrite && paddr == `ADDR_CLEAR |-> prdata == 32'h0)
    else $error("clear readable");
  chk_ctrl_rsv: assert property (rd_ctl |-> prdata[23:20] == 4'h0) else $error("reserved set");
  // irq may only drop at a completed clear write
  chk_irq_hold: assert property ($fell(timer_irq) |-> $past(clr_wr)) else $error("irq lost");
  cover property (clr_wr);
  cover property (pready && pslverr);
  cover property ($rose(timer_irq));
endmodule : gp_timer_checker
bind gp_timer gp_timer_checker #(.NUM_EVENTS(NUM_EVENTS)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .osc_32k(osc_32k), .secondary_clock(secondary_clock),
  .external_count_pin(external_count_pin), .low_power_mode(low_power_mode),
  .irq_sources(irq_sources), .timer_irq(timer_irq));
`default_nettype wire

/* gp_timer_map.svh */
// register map, field codes and count limits of the general purpose timer
`ifndef GP_TIMER_MAP_SVH
`define GP_TIMER_MAP_SVH

`define ADDR_RELOAD      32'hFFFF0320
`define ADDR_COUNT       32'hFFFF0324
`define ADDR_CONTROL     32'hFFFF0328
`define ADDR_CLEAR       32'hFFFF032C
`define ADDR_CAPTURE     32'hFFFF0330

`define RST_WORD         32'h00000000
`define RST_BYTE         8'h00
`define RST_PRESC        15'h0000

`define CLK_SEL_OSC      3'h0
`define CLK_SEL_CORE     3'h1
`define CLK_SEL_SEC      3'h2
`define CLK_SEL_PIN      3'h3

`define FMT_HMS_23       2'h2
`define FMT_HMS_255      2'h3

`define HUND_MAX         8'h63
`define SEXA_MAX         8'h3B
`define HOUR_MAX_23      8'h17
`define HOUR_MAX_255     8'hFF

`define POST_WE_BIT      23
`define EVENT_COUNT      18
`define PRESC_WIDTH      15

`endif

/* gp_timer_pkg.sv */
// types shared by the general purpose timer modules
`default_nettype none
package gp_timer_pkg;

  typedef struct packed {
    logic [7:0] post;
    logic       post_we;
    logic [2:0] rsv;
    logic       cmp_flag;
    logic       int_sel;
    logic       cap_en;
    logic [4:0] evt_sel;
    logic [2:0] clk_sel;
    logic       up;
    logic       en;
    logic       periodic;
    logic [1:0] fmt;
    logic [3:0] presc;
  } ctrl_t;

endpackage : gp_timer_pkg
`default_nettype wire

/* testbench.sv */
// self-checking bench of the general purpose timer
`timescale 1ns/1ps
`default_nettype none
`include "gp_timer_map.svh"
module testbench;
  localparam logic [31:0] a_ld = `ADDR_RELOAD, a_cnt = `ADDR_COUNT, a_ctl = `ADDR_CONTROL;
  localparam logic [31:0] a_clr = `ADDR_CLEAR, a_cap = `ADDR_CAPTURE;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        osc_32k = 1'b0, secondary_clock = 1'b0, external_count_pin = 1'b0, low_power_mode = 1'b0;
  logic        pready, pslverr, timer_irq, er;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [17:0] irq_sources = 18'h0;
  int          err_count, cmp_count, cyc;
  gp_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_32k(osc_32k), .secondary_clock(secondary_clock), .external_count_pin(external_count_pin),
    .low_power_mode(low_power_mode), .irq_sources(irq_sources), .timer_irq(timer_irq));
  initial begin
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdchk(input logic [31:0] a, e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  // pin is sampled, so each level is held at least two cycles
  task pulse(input int n);
    repeat (n) begin
      @(posedge pclk);
      external_count_pin <= 1'b1;
      repeat (2) @(posedge pclk);
      external_count_pin <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask : pulse
  // oscillator or secondary level, sampled like the pin
  task tog(input logic sec, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (sec) secondary_clock <= 1'b1;
      else osc_32k <= 1'b1;
      repeat (2) @(posedge pclk);
      secondary_clock <= 1'b0;
      osc_32k <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask : tog
  task step(input logic [31:0] ld, c, e);
    apb(1'b1, a_ctl, c);
    apb(1'b1, a_ld, ld);
    apb(1'b1, a_clr, 32'hA5);
    pulse(1);
    rdchk(a_cnt, e);
  endtask : step
  task t_regs();
    rdchk(a_ld, 32'h0);
    rdchk(a_ctl, 32'h0);
    rdchk(a_cap, 32'h0);
    apb(1'b0, 32'hFFFF0334, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, a_ld, 32'h12345678);
    rdchk(a_ld, 32'h12345678);
    apb(1'b1, a_cnt, 32'hFFFF);
    rdchk(a_cnt, 32'h0);
    apb(1'b1, a_clr, 32'h0);
    rdchk(a_cnt, 32'h12345678);
    apb(1'b1, a_ctl, 32'hA5F00000);
    rdchk(a_ctl, 32'hA5000000);
    apb(1'b1, a_ctl, 32'h5A000000);
    rdchk(a_ctl, 32'hA5000000);
    $display("regs done");
  endtask : t_regs
  task t_count();
    low_power_mode <= 1'b1;
    step(32'hA, 32'h680, 32'h9);
    pulse(3);
    rdchk(a_cnt, 32'h6);
    apb(1'b1, a_ctl, 32'h600);
    pulse(2);
    rdchk(a_cnt, 32'h6);
    low_power_mode <= 1'b0;
    step(32'h63, 32'h7A0, 32'h100);
    step(32'h63, 32'h780, 32'h64);
    step(32'h63, 32'h790, 32'h64);
    step(32'h173B3B63, 32'h7A0, 32'h0);
    step(32'h173B3B63, 32'h7B0, 32'h18000000);
    step(32'h0, 32'h6B0, 32'hFF3B3B63);
    step(32'h0, 32'h680, 32'hFFFFFFFF);
    chk({31'h0, timer_irq}, 32'h1);
    rdchk(a_ld, 32'h0);
    apb(1'b1, a_clr, 32'h3C);
    @(posedge pclk);
    chk({31'h0, timer_irq}, 32'h0);
    step(32'h1, 32'h6C0, 32'h0);
    pulse(1);
    rdchk(a_cnt, 32'h1);
    $display("count done");
  endtask : t_count
  task pres(input logic lp, input logic [31:0] c, input int n, lo, hi);
    low_power_mode <= lp;
    apb(1'b1, a_ctl, c & 32'hFFFFFF7F);
    apb(1'b1, a_clr, 32'h0);
    apb(1'b1, a_ctl, c);
    repeat (n) @(posedge pclk);
    apb(1'b1, a_ctl, c & 32'hFFFFFF7F);
    apb(1'b0, a_cnt, 32'h0);
    cmp_count++;
    if ((rd >= lo && rd <= hi) !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %0t count %h", $time, rd);
    end
    low_power_mode <= 1'b0;
  endtask : pres
  task t_pres();
    apb(1'b1, a_ld, 32'h0);
    pres(1'b0, 32'h380, 20, 20, 26);
    pres(1'b0, 32'h384, 160, 9, 11);
    pres(1'b0, 32'h388, 512, 1, 3);
    pres(1'b0, 32'h38F, 33000, 1, 1);
    pres(1'b1, 32'h380, 20, 0, 0);
    $display("prescale done");
  endtask : t_pres
  task t_cap();
    step(32'h55, 32'h23680, 32'h54);
    irq_sources[3] <= 1'b1;
    repeat (3) @(posedge pclk);
    rdchk(a_cap, 32'h54);
    pulse(1);
    rdchk(a_cnt, 32'h53);
    irq_sources[3] <= 1'b0;
    apb(1'b1, a_ctl, 32'h03680);
    irq_sources[3] <= 1'b1;
    repeat (3) @(posedge pclk);
    rdchk(a_cap, 32'h54);
    $display("capture done");
  endtask : t_cap
  task t_post();
    apb(1'b1, a_ld, 32'h0);
    apb(1'b1, a_ctl, 32'h018406C0);
    apb(1'b1, a_clr, 32'h0);
    pulse(1);
    chk({31'h0, timer_irq}, 32'h0);
    rdchk(a_ctl, 32'h010406C0);
    pulse(1);
    chk({31'h0, timer_irq}, 32'h1);
    rdchk(a_ctl, 32'h010C06C0);
    apb(1'b1, a_clr, 32'hFF);
    rdchk(a_ctl, 32'h010406C0);
    chk({31'h0, timer_irq}, 32'h0);
    $display("postscaler done");
  endtask : t_post
  task t_src();
    low_power_mode <= 1'b1;
    apb(1'b1, a_ctl, 32'h80);
    apb(1'b1, a_ld, 32'h10);
    apb(1'b1, a_clr, 32'h0);
    tog(1'b0, 2);
    rdchk(a_cnt, 32'hE);
    apb(1'b1, a_ctl, 32'h480);
    tog(1'b1, 2);
    rdchk(a_cnt, 32'hE);
    low_power_mode <= 1'b0;
    tog(1'b1, 2);
    rdchk(a_cnt, 32'hC);
    $display("source done");
  endtask : t_src
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_count();
    t_pres();
    t_cap();
    t_post();
    t_src();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
